// ==== core/altm_byte_if.sv ====
// byte stream from the manchester decoder to the transaction parser
`timescale 1ns/1ps
interface altm_byte_if;
    logic valid;
    logic [7:0] data;
    logic start;
    logic stop;
    modport src (output valid, output data, output start, output stop);
    modport dst (input valid, input data, input start, input stop);
endinterface

// ==== core/altm_manch_rx.sv ====
// manchester receiver for the auxiliary channel, emits bytes of a frame
`timescale 1ns/1ps
module altm_manch_rx
    import altm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_en,
    input wire logic i_aux,
    altm_byte_if.src o_bytes
);
    // ------------------------------------------------------------
    // bit recovery: mid-bit edges resynchronise a sample counter
    // ------------------------------------------------------------
    logic aux_d_r, aux_d_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic [7:0] idle_r, idle_nxt;
    logic in_frame_r, in_frame_nxt;
    logic synced_r, synced_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] nbit_r, nbit_nxt;
    logic valid_r, valid_nxt;
    logic [7:0] data_r, data_nxt;
    logic start_r, start_nxt;
    logic stop_r, stop_nxt;
    logic edge_w;

    assign o_bytes.valid = valid_r;
    assign o_bytes.data = data_r;
    assign o_bytes.start = start_r;
    assign o_bytes.stop = stop_r;

    always_comb begin
        aux_d_nxt = i_aux;
        edge_w = (i_aux != aux_d_r);
        cnt_nxt = cnt_r;
        idle_nxt = edge_w ? 8'h00 : idle_r;
        in_frame_nxt = in_frame_r;
        synced_nxt = synced_r;
        shift_nxt = shift_r;
        nbit_nxt = nbit_r;
        valid_nxt = 1'b0;
        data_nxt = data_r;
        start_nxt = 1'b0;
        stop_nxt = 1'b0;
        if (!i_en) begin
            // snooper idle in tmds modes
            in_frame_nxt = 1'b0;
            synced_nxt = 1'b0;
        end else begin
            if (!edge_w && idle_r != CNT_IDLE) begin
                idle_nxt = idle_r + 8'h01;
            end
            // a mid-bit edge (at or after 3/4 bit) restarts the counter
            if (edge_w && cnt_r >= CNT_RESYNC) begin
                cnt_nxt = 8'h00;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
            if (cnt_r == CNT_SAMPLE && in_frame_r) begin // RULE2
                // second half of the bit: low means logic one
                shift_nxt = {shift_r[6:0], ~aux_d_r};
                if (!synced_r) begin
                    // hunt for the end of the preamble pattern
                    if ({shift_r[6:0], ~aux_d_r} == SYNC_END) begin
                        synced_nxt = 1'b1;
                        nbit_nxt = 3'h0;
                        start_nxt = 1'b1;
                    end
                end else begin
                    nbit_nxt = nbit_r + 3'h1;
                    if (nbit_r == 3'h7) begin
                        valid_nxt = 1'b1;
                        data_nxt = {shift_r[6:0], ~aux_d_r};
                    end
                end
            end
            if (edge_w && !in_frame_r) begin
                in_frame_nxt = 1'b1;
                // first edge opens a bit, half a bit before its mid-bit
                cnt_nxt = 8'(HALF_CYC);
                shift_nxt = 8'h00;
            end
            // a quiet line ends the frame
            if (in_frame_r && idle_r == CNT_IDLE) begin
                in_frame_nxt = 1'b0;
                stop_nxt = synced_r;
                synced_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            aux_d_r <= 1'b1;
            cnt_r <= 8'h00;
            idle_r <= 8'h00;
            in_frame_r <= 1'b0;
            synced_r <= 1'b0;
            shift_r <= 8'h00;
            nbit_r <= 3'h0;
            valid_r <= 1'b0;
            data_r <= 8'h00;
            start_r <= 1'b0;
            stop_r <= 1'b0;
        end else begin
            aux_d_r <= aux_d_nxt;
            cnt_r <= cnt_nxt;
            idle_r <= idle_nxt;
            in_frame_r <= in_frame_nxt;
            synced_r <= synced_nxt;
            shift_r <= shift_nxt;
            nbit_r <= nbit_nxt;
            valid_r <= valid_nxt;
            data_r <= data_nxt;
            start_r <= start_nxt;
            stop_r <= stop_nxt;
        end
    end

    property p_no_byte_disabled;
        @(posedge i_clk) disable iff (i_rst)
        !i_en ##1 !i_en |-> !valid_r;
    endproperty
    a_no_byte_disabled: assert property (p_no_byte_disabled) // RULE3
        else $error("byte emitted while receiver disabled");
endmodule

// ==== core/altm_monitor.sv ====
// auxiliary link training monitor: snoops training writes, drives settings
`timescale 1ns/1ps
// How it works
// RULE1: snoop training writes in displayport mode only
// RULE2: decode 1 Mbps manchester auxiliary frames
// RULE3: snooper idle during any tmds mode
// RULE4: writes to reserved bits are ignored
// RULE5: rate codes 06h/0Ah/14h, default 2.7
// RULE6: unknown rate code falls back to 5.4
// RULE7: rate reads back as 00h/01h/02h
// RULE8: lane codes 0/1/2/4, default all off
// RULE9: unknown lane code turns lanes off
// RULE10: lane count reads back as lane mask
// RULE11: dp mode: dp selected, cable detect low
// RULE12: tmds mode: cable detect high or hdmi
// RULE13: equalizer gain applied after training completes
// RULE14: per-level equalizer default 0 dB, settable
// RULE15: per-lane swing/pre-emphasis, bad pairs disable lanes
// RULE16: update only on acknowledged complete writes
module altm_monitor
    import altm_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_dp_select,
    input wire logic i_sink_cable_detect,
    input wire logic i_aux,
    input wire logic i_training_done,
    input wire logic [15:0] i_per_lane_level_eq_setting,
    output logic o_dp_mode,
    output logic o_tmds_mode,
    output logic [7:0] o_link_rate_setting,
    output logic [7:0] o_active_lane_count,
    output logic [3:0] o_lane_enable,
    output logic [7:0] o_output_swing_level,
    output logic [7:0] o_pre_emphasis_level,
    output logic [15:0] o_training_level_eq_gain
);
    // ------------------------------------------------------------
    // mode selection
    // ------------------------------------------------------------
    logic dp_mode_w;
    assign dp_mode_w = i_dp_select && !i_sink_cable_detect; // RULE11

    altm_byte_if bytes_if ();

    altm_manch_rx u_rx (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_en(dp_mode_w), // RULE1 RULE3
        .i_aux(i_aux),
        .o_bytes(bytes_if.src)
    );

    // ------------------------------------------------------------
    // transaction parser
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ALTM_REQ,
        ALTM_WAIT_REPLY,
        ALTM_REPLY
    } altm_state_e;

    altm_state_e st_r, st_nxt;
    logic [3:0] bidx_r, bidx_nxt;
    logic is_wr_r, is_wr_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [3:0] len_r, len_nxt;
    logic [7:0] pend_r [MAX_BYTES], pend_nxt [MAX_BYTES];
    logic [3:0] npend_r, npend_nxt;
    logic commit_w;

    always_comb begin
        st_nxt = st_r;
        bidx_nxt = bidx_r;
        is_wr_nxt = is_wr_r;
        addr_nxt = addr_r;
        len_nxt = len_r;
        pend_nxt = pend_r;
        npend_nxt = npend_r;
        commit_w = 1'b0;
        if (!dp_mode_w) begin
            st_nxt = ALTM_REQ; // RULE3
            bidx_nxt = 4'h0;
            is_wr_nxt = 1'b0;
        end else begin
            case (st_r)
                ALTM_REQ: begin
                    if (bytes_if.start) begin
                        bidx_nxt = 4'h0;
                        npend_nxt = 4'h0;
                        is_wr_nxt = 1'b0;
                    end else if (bytes_if.valid) begin
                        bidx_nxt = bidx_r + 4'h1;
                        if (bidx_r == 4'h0) begin
                            is_wr_nxt = bytes_if.data[7:4] == CMD_NATIVE_WR;
                            addr_nxt[19:16] = bytes_if.data[3:0];
                        end else if (bidx_r == 4'h1) begin
                            addr_nxt[15:8] = bytes_if.data;
                        end else if (bidx_r == 4'h2) begin
                            addr_nxt[7:0] = bytes_if.data;
                        end else if (bidx_r == 4'h3) begin
                            len_nxt = bytes_if.data[3:0];
                        end else if (npend_r != 4'(MAX_BYTES)) begin
                            pend_nxt[npend_r[2:0]] = bytes_if.data;
                            npend_nxt = npend_r + 4'h1;
                        end
                    end else if (bytes_if.stop) begin
                        // only a complete write waits for its reply
                        if (is_wr_r && npend_r != 4'h0 &&
                            npend_r == len_r + 4'h1) begin
                            st_nxt = ALTM_WAIT_REPLY;
                        end
                    end
                end
                ALTM_WAIT_REPLY: begin
                    if (bytes_if.start) begin
                        st_nxt = ALTM_REPLY;
                    end
                end
                ALTM_REPLY: begin
                    if (bytes_if.valid) begin
                        // the reply's first byte carries the ack code
                        commit_w = bytes_if.data[7:4] == REPLY_ACK; // RULE16
                        st_nxt = ALTM_REQ;
                        // the reply's own end must not re-arm a wait
                        is_wr_nxt = 1'b0;
                    end else if (bytes_if.stop) begin
                        st_nxt = ALTM_REQ;
                    end
                end
                default: begin
                    st_nxt = ALTM_REQ;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_r <= ALTM_REQ;
            bidx_r <= 4'h0;
            is_wr_r <= 1'b0;
            addr_r <= 20'h00000;
            len_r <= 4'h0;
            pend_r <= '{default: 8'h00};
            npend_r <= 4'h0;
        end else begin
            st_r <= st_nxt;
            bidx_r <= bidx_nxt;
            is_wr_r <= is_wr_nxt;
            addr_r <= addr_nxt;
            len_r <= len_nxt;
            pend_r <= pend_nxt;
            npend_r <= npend_nxt;
        end
    end

    // ------------------------------------------------------------
    // settings update
    // ------------------------------------------------------------
    logic [1:0] rate_r, rate_nxt;
    logic [3:0] mask_r, mask_nxt;
    logic [1:0] swing_r [4], swing_nxt [4];
    logic [1:0] pre_r [4], pre_nxt [4];
    logic [3:0] bad_r, bad_nxt;
    logic [3:0] eq_r [4], eq_nxt [4];
    logic dpm_r, tmds_r, lane_en_any;
    logic [19:0] a;

    always_comb begin
        rate_nxt = rate_r;
        mask_nxt = mask_r;
        swing_nxt = swing_r;
        pre_nxt = pre_r;
        bad_nxt = bad_r;
        eq_nxt = eq_r;
        a = 20'h00000;
        if (commit_w) begin
            // burst writes cover consecutive addresses
            for (int i = 0; i < MAX_BYTES; i++) begin
                a = addr_r + 20'(i);
                if (4'(i) < npend_r) begin
                    if (a == ADDR_LINK_RATE) begin
                        rate_nxt = rate_decode(pend_r[i]); // RULE5 RULE6
                    end else if (a == ADDR_LANE_CNT) begin
                        // bits 7:5 reserved and dropped
                        mask_nxt = lane_decode(pend_r[i][4:0]); // RULE4 RULE8 RULE9
                    end else if (a >= ADDR_LANE0_SET && a <= ADDR_LANE3_SET) begin
                        swing_nxt[a[1:0]+2'h1] = pend_r[i][SWING_LSB+:2]; // RULE15
                        pre_nxt[a[1:0]+2'h1] = pend_r[i][PRE_LSB+:2];
                        bad_nxt[a[1:0]+2'h1] = drive_bad(
                            pend_r[i][SWING_LSB+:2], pend_r[i][PRE_LSB+:2]);
                    end
                end
            end
        end
        // level-indexed gain held until training completes
        if (i_training_done) begin // RULE13
            for (int l = 0; l < 4; l++) begin
                eq_nxt[l] = i_per_lane_level_eq_setting[4*l+:4]; // RULE14
            end
        end
    end

    assign lane_en_any = (bad_r == 4'h0); // RULE15

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rate_r <= RATE_RESET;
            mask_r <= LANE_RESET;
            swing_r <= '{default: 2'h0};
            pre_r <= '{default: 2'h0};
            bad_r <= 4'h0;
            eq_r <= '{default: EQ_GAIN_0DB};
            dpm_r <= 1'b0;
            tmds_r <= 1'b0;
        end else begin
            rate_r <= rate_nxt;
            mask_r <= mask_nxt;
            swing_r <= swing_nxt;
            pre_r <= pre_nxt;
            bad_r <= bad_nxt;
            eq_r <= eq_nxt;
            dpm_r <= dp_mode_w;
            tmds_r <= !dp_mode_w; // RULE12
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dp_mode <= 1'b0;
            o_tmds_mode <= 1'b0;
            o_link_rate_setting <= 8'h01;
            o_active_lane_count <= 8'h00;
            o_lane_enable <= 4'h0;
            o_output_swing_level <= 8'h00;
            o_pre_emphasis_level <= 8'h00;
            o_training_level_eq_gain <= 16'h0000;
        end else begin
            o_dp_mode <= dpm_r;
            o_tmds_mode <= tmds_r;
            o_link_rate_setting <= {6'h00, rate_r}; // RULE7
            o_active_lane_count <= {4'h0, mask_r}; // RULE10
            o_lane_enable <= lane_en_any ? mask_r : 4'h0;
            o_output_swing_level <= {swing_r[3], swing_r[2],
                                     swing_r[1], swing_r[0]};
            o_pre_emphasis_level <= {pre_r[3], pre_r[2], pre_r[1], pre_r[0]};
            o_training_level_eq_gain <= {eq_r[3], eq_r[2], eq_r[1], eq_r[0]};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // a disabled snooper neither commits nor leaves the idle state
    property p_no_commit_tmds;
        @(posedge i_clk) disable iff (i_rst)
        !dp_mode_w |-> !commit_w ##1 (st_r == ALTM_REQ);
    endproperty
    a_no_commit_tmds: assert property (p_no_commit_tmds) // RULE3
        else $error("commit while in tmds mode");

    property p_rate_code;
        @(posedge i_clk) disable iff (i_rst)
        rate_r != 2'h3;
    endproperty
    a_rate_code: assert property (p_rate_code) // RULE7
        else $error("illegal rate code");

    property p_lane_mask;
        @(posedge i_clk) disable iff (i_rst)
        mask_r == 4'h0 || mask_r == 4'h1 || mask_r == 4'h3 || mask_r == 4'hF;
    endproperty
    a_lane_mask: assert property (p_lane_mask) // RULE10
        else $error("lane mask outside the defined set");

    property p_bad_off;
        @(posedge i_clk) disable iff (i_rst)
        bad_r != 4'h0 |-> ##1 o_lane_enable == 4'h0;
    endproperty
    a_bad_off: assert property (p_bad_off) // RULE15
        else $error("lanes on with bad drive pair");

    property p_tmds_out;
        @(posedge i_clk) disable iff (i_rst)
        !dp_mode_w |-> ##2 o_tmds_mode && !o_dp_mode;
    endproperty
    a_tmds_out: assert property (p_tmds_out) // RULE12
        else $error("tmds mode not reported");

    property p_commit_write;
        @(posedge i_clk) disable iff (i_rst)
        commit_w |-> is_wr_r && st_r == ALTM_REPLY;
    endproperty
    a_commit_write: assert property (p_commit_write) // RULE16
        else $error("commit without a pending write");
endmodule

// ==== core/altm_pkg.sv ====
// shared constants for the auxiliary link training monitor
package altm_pkg;
    // ------------------------------------------------------------
    // auxiliary channel timing (1 Mbps manchester, 100 MHz clock)
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int AUX_KBPS = 1000;
    localparam int BIT_CYC = CLK_MHZ * 1000 / AUX_KBPS;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int SAMPLE_CYC = BIT_CYC / 4;
    localparam int IDLE_CYC = BIT_CYC * 2;
    localparam logic [7:0] CNT_SAMPLE = 8'(SAMPLE_CYC);
    localparam logic [7:0] CNT_RESYNC = 8'(HALF_CYC + SAMPLE_CYC);
    localparam logic [7:0] CNT_IDLE = 8'(IDLE_CYC);

    // ------------------------------------------------------------
    // configuration data addresses and command codes
    // ------------------------------------------------------------
    localparam logic [19:0] ADDR_LINK_RATE = 20'h00100;
    localparam logic [19:0] ADDR_LANE_CNT = 20'h00101;
    localparam logic [19:0] ADDR_LANE0_SET = 20'h00103;
    localparam logic [19:0] ADDR_LANE3_SET = 20'h00106;
    localparam logic [3:0] CMD_NATIVE_WR = 4'h8;
    localparam logic [3:0] CMD_NATIVE_RD = 4'h9;
    localparam logic [3:0] REPLY_ACK = 4'h0;
    localparam logic [7:0] SYNC_END = 8'h0F;

    // ------------------------------------------------------------
    // field codes
    // ------------------------------------------------------------
    localparam logic [7:0] RATE_W_162 = 8'h06;
    localparam logic [7:0] RATE_W_270 = 8'h0A;
    localparam logic [7:0] RATE_W_540 = 8'h14;
    localparam logic [1:0] RATE_162 = 2'h0;
    localparam logic [1:0] RATE_270 = 2'h1;
    localparam logic [1:0] RATE_540 = 2'h2;
    localparam logic [1:0] RATE_RESET = RATE_270;
    localparam logic [4:0] LANE_W_0 = 5'h00;
    localparam logic [4:0] LANE_W_1 = 5'h01;
    localparam logic [4:0] LANE_W_2 = 5'h02;
    localparam logic [4:0] LANE_W_4 = 5'h04;
    localparam logic [3:0] LANE_RESET = 4'h0;
    localparam int SWING_LSB = 0;
    localparam int PRE_LSB = 3;
    localparam logic [1:0] EQ_LEVEL_RESET = 2'h0;
    localparam logic [3:0] EQ_GAIN_0DB = 4'h0;
    localparam int MAX_BYTES = 8;

    typedef enum logic [1:0] {ALTM_HDMI, ALTM_DP} altm_sel_e;

    // write decode of the link-rate field into the compact read code
    function automatic logic [1:0] rate_decode(input logic [7:0] w);
        if (w == RATE_W_162) begin
            return RATE_162;
        end else if (w == RATE_W_270) begin
            return RATE_270;
        end else begin
            return RATE_540;
        end
    endfunction

    // write decode of the lane-count field into the lane mask
    function automatic logic [3:0] lane_decode(input logic [4:0] w);
        if (w == LANE_W_1) begin
            return 4'h1;
        end else if (w == LANE_W_2) begin
            return 4'h3;
        end else if (w == LANE_W_4) begin
            return 4'hF;
        end else begin
            return 4'h0;
        end
    endfunction

    // swing/pre-emphasis pairs that are not allowed
    function automatic logic drive_bad(input logic [1:0] sw,
                                       input logic [1:0] pe);
        return (sw == 2'h1 && pe == 2'h3) || (sw == 2'h2 && pe[1]);
    endfunction
endpackage

// ==== dv/altm_aux_src.sv ====
// source-side model: sends manchester frames on the auxiliary line
`timescale 1ns/1ps
module altm_aux_src
    import altm_pkg::*;
(
    input wire logic i_clk,
    output logic o_aux
);
    // the line idles high between frames
    initial o_aux = 1'b1;

    // ------------------------------------------------------------
    // bit and byte senders, one bit is BIT_CYC clocks
    // ------------------------------------------------------------
    // a one is high then low, a zero is low then high
    task automatic bit_out(input logic v);
        o_aux = v;
        repeat (HALF_CYC) @(negedge i_clk);
        o_aux = ~v;
        repeat (HALF_CYC) @(negedge i_clk);
    endtask

    task automatic byte_out(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
    endtask

    // ------------------------------------------------------------
    // whole frame: zero preamble, sync end, bytes msb first, idle
    // ------------------------------------------------------------
    // the idle tail outlasts the receiver's end-of-frame timeout
    task automatic frame(input logic [7:0] b [0:10], input int n);
        @(negedge i_clk);
        for (int i = 0; i < 16; i++) begin
            bit_out(1'b0);
        end
        byte_out(SYNC_END);
        for (int i = 0; i < n; i++) begin
            byte_out(b[i]);
        end
        o_aux = 1'b1;
        repeat (IDLE_CYC + BIT_CYC) @(negedge i_clk);
    endtask
endmodule

// ==== dv/aux_link_training_monitor_bench.sv ====
// self-checking bench for the auxiliary link training monitor
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("wrong value %s expected %0h seen %0h", nm, e, g); \
    end \
end
module aux_link_training_monitor_bench;
    import altm_pkg::*;
    logic i_clk, i_rst, i_dp_select, i_sink_cable_detect, i_aux;
    logic i_training_done;
    logic [15:0] i_per_lane_level_eq_setting;
    logic o_dp_mode, o_tmds_mode;
    logic [7:0] o_link_rate_setting, o_active_lane_count;
    logic [3:0] o_lane_enable;
    logic [7:0] o_output_swing_level, o_pre_emphasis_level;
    logic [15:0] o_training_level_eq_gain;
    logic [7:0] fr [0:10];
    logic [7:0] dat [0:6];
    logic [7:0] rate_x, lane_x, sw_x, pe_x;
    logic [3:0] en_x;
    logic bad_x;
    int n_mismatch, n_tests, bl;
    int cyc = 0;
    localparam logic [7:0] RATES [0:3] = '{8'h33, 8'h06, 8'h0A, 8'h14};
    localparam logic [4:0] LANES [0:3] = '{5'h03, 5'h01, 5'h02, 5'h04};
    localparam logic [7:0] BADS [0:2] = '{8'h19, 8'h12, 8'h1A};

    altm_monitor dut (.i_clk(i_clk), .i_rst(i_rst),
        .i_dp_select(i_dp_select),
        .i_sink_cable_detect(i_sink_cable_detect), .i_aux(i_aux),
        .i_training_done(i_training_done),
        .i_per_lane_level_eq_setting(i_per_lane_level_eq_setting),
        .o_dp_mode(o_dp_mode), .o_tmds_mode(o_tmds_mode),
        .o_link_rate_setting(o_link_rate_setting),
        .o_active_lane_count(o_active_lane_count),
        .o_lane_enable(o_lane_enable),
        .o_output_swing_level(o_output_swing_level),
        .o_pre_emphasis_level(o_pre_emphasis_level),
        .o_training_level_eq_gain(o_training_level_eq_gain));
    altm_aux_src src (.i_clk(i_clk), .o_aux(i_aux));

    // ------------------------------------------------------------
    // clock, hang guard and verdict
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // six transfers of about 15000 clocks each, plus margin
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic results();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // expected-value functions
    // ------------------------------------------------------------
    function automatic logic [7:0] f_rate(input logic [7:0] w);
        case (w)
            8'h06: return 8'h00;
            8'h0A: return 8'h01;
            default: return 8'h02;
        endcase
    endfunction

    // only bits 4:0 count, the rest are reserved
    function automatic logic [7:0] f_lane(input logic [7:0] w);
        case (w[4:0])
            5'h01: return 8'h01;
            5'h02: return 8'h03;
            5'h04: return 8'h0F;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic f_bad(input logic [7:0] w);
        return (w[1:0] == 2'h1 && w[4:3] == 2'h3) ||
               (w[1:0] == 2'h2 && w[4]);
    endfunction

    // ------------------------------------------------------------
    // stimulus and checking tasks
    // ------------------------------------------------------------
    // data for 100h..106h; 102h is not watched and gets noise
    task automatic gen(input logic [7:0] r, input logic [7:0] l,
                       input logic bad);
        dat[0] = r;
        dat[1] = l;
        dat[2] = 8'($urandom);
        bl = bad ? int'($urandom_range(3, 0)) : -1;
        for (int n = 0; n < 4; n++) begin
            do begin
                dat[3+n] = 8'($urandom);
            end while (f_bad(dat[3+n]));
            if (n == bl) begin
                dat[3+n] = BADS[$urandom_range(2, 0)] | 8'($urandom) & 8'hE4;
            end
        end
    endtask

    // write request to 100h, then the reply frame
    task automatic xfer(input logic [7:0] rep);
        fr[0] = {CMD_NATIVE_WR, ADDR_LINK_RATE[19:16]};
        fr[1] = ADDR_LINK_RATE[15:8];
        fr[2] = ADDR_LINK_RATE[7:0];
        fr[3] = 8'h06;
        for (int i = 0; i < 7; i++) begin
            fr[4+i] = dat[i];
        end
        src.frame(fr, 11);
        fr[0] = rep;
        src.frame(fr, 1);
        repeat (10) @(negedge i_clk);
    endtask

    task automatic expect_write();
        rate_x = f_rate(dat[0]);
        lane_x = f_lane(dat[1]);
        bad_x = 1'b0;
        for (int n = 0; n < 4; n++) begin
            bad_x |= f_bad(dat[3+n]);
            sw_x[2*n +: 2] = dat[3+n][1:0];
            pe_x[2*n +: 2] = dat[3+n][4:3];
        end
        en_x = bad_x ? 4'h0 : lane_x[3:0];
    endtask

    task automatic chk_set();
        `CHK("link rate", rate_x, o_link_rate_setting)
        `CHK("lane count", lane_x, o_active_lane_count)
        `CHK("lane enable", en_x, o_lane_enable)
        `CHK("swing", sw_x, o_output_swing_level)
        `CHK("pre-emphasis", pe_x, o_pre_emphasis_level)
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        i_rst = 1'b1;
        i_dp_select = 1'b1;
        i_sink_cable_detect = 1'b0;
        i_training_done = 1'b0;
        i_per_lane_level_eq_setting = 16'h0000;
        n_mismatch = 0;
        n_tests = 0;
        rate_x = 8'h01;
        lane_x = 8'h00;
        sw_x = 8'h00;
        pe_x = 8'h00;
        en_x = 4'h0;
        bad_x = 1'b0;
        void'($urandom(88689));
        repeat (20) @(negedge i_clk);
        chk_set();
        `CHK("eq gain", 16'h0000, o_training_level_eq_gain)
        i_rst = 1'b0;
        for (int m = 0; m < 4; m++) begin
            i_dp_select = m[0];
            i_sink_cable_detect = m[1];
            repeat (3) @(negedge i_clk);
            `CHK("dp mode", (m == 1), o_dp_mode)
            `CHK("tmds mode", (m != 1), o_tmds_mode)
        end
        i_dp_select = 1'b1;
        i_sink_cable_detect = 1'b0;
        // gain must wait for the end of training
        i_per_lane_level_eq_setting = 16'($urandom) | 16'h0001;
        repeat (5) @(negedge i_clk);
        `CHK("eq gain", 16'h0000, o_training_level_eq_gain)
        i_training_done = 1'b1;
        repeat (4) @(negedge i_clk);
        `CHK("eq gain", i_per_lane_level_eq_setting,
             o_training_level_eq_gain)
        i_training_done = 1'b0;
        // bad codes first, then every rate code and lane codes 1/2/4; one bad pair
        for (int k = 0; k < 4; k++) begin
            gen(RATES[k], {3'($urandom), LANES[k]}, k == 1);
            xfer({REPLY_ACK, 4'h0});
            expect_write();
            chk_set();
        end
        // a refused reply, then acknowledged traffic in tmds mode
        for (int k = 0; k < 2; k++) begin
            gen(RATES[1], {3'h0, LANES[1]}, 1'b0);
            i_sink_cable_detect = k[0];
            xfer(k ? 8'h00 : 8'h10);
            chk_set();
        end
        results();
    end
endmodule
